// ---- rtl/mat_pkg.sv ----
// What this block does
// - Egress ports from destination MAC plus VLAN
// - Static and dynamic entries both serve lookup
// - Source MAC learns or refreshes dynamic entry
// - Dynamic entry removed after age time idle
// - Age time is 300 seconds after reset
// - Age time accepted only from 10 to 10000000
// - Aging can be switched off entirely
// - Auto mode learns unknown source, disabled learns nothing
// - Secure mode passes static sources, drops others
// - Internal function may own and lock port mode
// - Static table: 64 entries, VLAN, MAC, ports
// - Static entries ordered by VLAN then MAC
// - Whole table 8256 entries (64 static plus 8192 dynamic), VLAN then MAC order
// - Entry marked deleted lives until next commit
// - Read returns exact match or next entry
// - Get-next continues; end flag when exhausted
// - Read result carries type, VLAN, MAC, ports
package mat_pkg;
  // ==========================================================
  // Geometry
  localparam int NPORT = 8;
  localparam int PW = 3;
  localparam int VW = 12;
  localparam int MW = 48;
  localparam int KW = VW + MW;
  localparam int DYN_DEPTH = 8192;
  localparam int DAW = 13;
  localparam int ST_DEPTH = 64;
  localparam int SAW = 6;
  localparam int TW = 24;
  localparam logic [13:0] SCAN_LAST = 14'h203f;
  // ==========================================================
  // Timing: one second of sys_clk
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEC_NS = 1000000000;
  localparam int SEC_CYC = SEC_NS / CLK_PERIOD_NS;
  localparam logic [TW-1:0] AGE_RST = 24'h00012c;
  localparam logic [TW-1:0] AGE_MIN = 24'h00000a;
  localparam logic [TW-1:0] AGE_MAX = 24'h989680;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AGE = 8'h04;
  localparam logic [7:0] REG_LMODE = 8'h08;
  localparam logic [7:0] REG_LOCK = 8'h0c;
  localparam logic [7:0] REG_ST_VID = 8'h10;
  localparam logic [7:0] REG_ST_MLO = 8'h14;
  localparam logic [7:0] REG_ST_MHI = 8'h18;
  localparam logic [7:0] REG_ST_PORTS = 8'h1c;
  localparam logic [7:0] REG_ST_CMD = 8'h20;
  localparam logic [7:0] REG_ST_STAT = 8'h24;
  localparam logic [7:0] REG_RD_VID = 8'h28;
  localparam logic [7:0] REG_RD_MLO = 8'h2c;
  localparam logic [7:0] REG_RD_MHI = 8'h30;
  localparam logic [7:0] REG_RD_CMD = 8'h34;
  localparam logic [7:0] REG_RD_STAT = 8'h38;
  localparam logic [7:0] REG_RES_VID = 8'h3c;
  localparam logic [7:0] REG_RES_MLO = 8'h40;
  localparam logic [7:0] REG_RES_MHI = 8'h44;
  localparam logic [7:0] REG_RES_PORTS = 8'h48;
  // Command bit positions
  localparam int CMD_ADD = 0;
  localparam int CMD_DEL = 1;
  localparam int CMD_COMMIT = 2;
  localparam int CMD_FIRST = 0;
  localparam int CMD_NEXT = 1;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LRN_AUTO = 2'b00,
    LRN_OFF = 2'b01,
    LRN_SECURE = 2'b10
  } mat_lrn_e;
  typedef enum logic {
    SC_IDLE = 1'b0,
    SC_RUN = 1'b1
  } mat_scan_e;
  // Fold a VLAN+MAC key into a dynamic table slot
  function automatic logic [DAW-1:0] mat_hash(input logic [KW-1:0] k);
    mat_hash = k[12:0] ^ k[25:13] ^ k[38:26] ^ k[51:39] ^ {5'h00, k[59:52]};
  endfunction
endpackage

// ---- rtl/mat_table.sv ----
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mat_table
  import mat_pkg::*;
#(
  parameter int CYC_PER_SEC = SEC_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frm_valid,
  input wire logic [PW-1:0] frm_port,
  input wire logic [VW-1:0] frm_vid,
  input wire logic [MW-1:0] destination_mac_address,
  input wire logic [MW-1:0] source_mac_address,
  input wire logic [NPORT-1:0] ovr_en,
  input wire logic [2*NPORT-1:0] ovr_mode,
  output logic fwd_valid,
  output logic [NPORT-1:0] fwd_ports,
  output logic fwd_drop,
  output logic fwd_flood
);
  // ==========================================================
  // Storage
  logic [KW-1:0] dyn_key_ff [DYN_DEPTH]; // Learned keys
  logic [PW-1:0] dyn_port_ff [DYN_DEPTH]; // Learned port
  logic [TW-1:0] dyn_stamp_ff [DYN_DEPTH]; // Second of last sighting
  logic [DYN_DEPTH-1:0] dyn_vld_ff; // Slot in use
  logic [KW-1:0] st_key_ff [ST_DEPTH]; // Static keys
  logic [NPORT-1:0] st_ports_ff [ST_DEPTH]; // Live member set
  logic [NPORT-1:0] st_pend_ff [ST_DEPTH]; // Staged member set
  logic [ST_DEPTH-1:0] st_vld_ff; // Live static entry
  logic [ST_DEPTH-1:0] st_add_ff; // Add staged
  logic [ST_DEPTH-1:0] st_del_ff; // Delete staged
  // Control registers
  logic aging_off_ff;
  logic [TW-1:0] age_time_ff;
  logic [2*NPORT-1:0] lrn_mode_ff;
  logic [VW-1:0] st_vid_ff;
  logic [MW-1:0] st_mac_ff;
  logic [NPORT-1:0] st_ports_in_ff;
  logic st_full_ff; // Last add found no slot
  logic [VW-1:0] rd_vid_ff;
  logic [MW-1:0] rd_mac_ff;
  // Bus answer
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  // Forward answer
  logic fwd_valid_ff;
  logic [NPORT-1:0] fwd_ports_ff;
  logic fwd_drop_ff;
  logic fwd_flood_ff;
  // Time base
  logic [31:0] pre_cnt_ff;
  logic [TW-1:0] now_sec_ff;
  logic [DAW-1:0] sweep_idx_ff;
  // Ordered reader
  mat_scan_e scan_st_ff;
  logic [13:0] scan_idx_ff;
  logic strict_ff;
  logic [KW-1:0] base_key_ff;
  logic best_vld_ff;
  logic best_static_ff;
  logic [KW-1:0] best_key_ff;
  logic [NPORT-1:0] best_ports_ff;
  logic [KW-1:0] res_key_ff;
  logic [NPORT-1:0] res_ports_ff;
  logic res_static_ff;
  logic res_end_ff;

  // ==========================================================
  // Bus strobes
  logic acc; // Completing access
  logic wr; // Completing write
  assign acc = psel && penable && pready_ff;
  assign wr = acc && pwrite;

  // ==========================================================
  // Frame lookup
  logic [KW-1:0] d_key, s_key;
  logic [DAW-1:0] d_idx, s_idx;
  logic d_st_hit, s_st_hit, d_dyn_hit;
  logic [NPORT-1:0] d_st_ports, src_mask;
  logic [1:0] eff_mode;
  logic secure_drop, learn;
  assign d_key = {frm_vid, destination_mac_address};
  assign s_key = {frm_vid, source_mac_address};
  assign d_idx = mat_hash(d_key);
  assign s_idx = mat_hash(s_key);
  assign d_dyn_hit = dyn_vld_ff[d_idx] && (dyn_key_ff[d_idx] == d_key);
  assign src_mask = NPORT'(1) << frm_port;

  // Parallel search of the static table for both addresses
  always_comb begin
    d_st_hit = 1'b0;
    s_st_hit = 1'b0;
    d_st_ports = '0;
    for (int i = 0; i < ST_DEPTH; i++) begin
      if (st_vld_ff[i] && st_key_ff[i] == d_key) begin
        d_st_hit = 1'b1;
        d_st_ports = st_ports_ff[i];
      end
      if (st_vld_ff[i] && st_key_ff[i] == s_key) begin
        s_st_hit = 1'b1;
      end
    end
  end

  // Owner of the port mode: internal function when it claims it
  assign eff_mode = ovr_en[frm_port] ? ovr_mode[2*frm_port +: 2] : lrn_mode_ff[2*frm_port +: 2];
  assign secure_drop = frm_valid && (eff_mode == LRN_SECURE) && !s_st_hit;
  // Learn only unknown or own slot; never shadow a static source
  assign learn = frm_valid && (eff_mode == LRN_AUTO) && !s_st_hit
    && (!dyn_vld_ff[s_idx] || dyn_key_ff[s_idx] == s_key);

  // Forwarding decision, one cycle after the frame
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_valid_ff <= 1'b0;
      fwd_ports_ff <= '0;
      fwd_drop_ff <= 1'b0;
      fwd_flood_ff <= 1'b0;
    end else begin
      fwd_valid_ff <= frm_valid;
      fwd_drop_ff <= secure_drop;
      fwd_flood_ff <= frm_valid && !secure_drop && !d_st_hit && !d_dyn_hit;
      if (!frm_valid || secure_drop) begin
        fwd_ports_ff <= '0;
      end else if (d_st_hit) begin
        fwd_ports_ff <= d_st_ports & ~src_mask;
      end else if (d_dyn_hit) begin
        fwd_ports_ff <= (NPORT'(1) << dyn_port_ff[d_idx]) & ~src_mask;
      end else begin
        fwd_ports_ff <= ~src_mask;
      end
    end
  end

  // ==========================================================
  // Seconds counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_ff <= '0;
      now_sec_ff <= '0;
    end else if (pre_cnt_ff == 32'(CYC_PER_SEC - 1)) begin
      pre_cnt_ff <= '0;
      now_sec_ff <= now_sec_ff + 1'b1;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 1'b1;
    end
  end

  // Aging sweep walks one slot per cycle, holding while learning writes
  logic expire;
  logic [TW-1:0] idle_sec;
  assign idle_sec = now_sec_ff - dyn_stamp_ff[sweep_idx_ff];
  assign expire = !learn && !aging_off_ff && dyn_vld_ff[sweep_idx_ff]
    && (idle_sec >= age_time_ff);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sweep_idx_ff <= '0;
    end else if (!learn) begin
      sweep_idx_ff <= sweep_idx_ff + 1'b1;
    end
  end

  // Dynamic slot occupancy
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dyn_vld_ff <= '0;
    end else if (learn) begin
      dyn_vld_ff[s_idx] <= 1'b1;
    end else if (expire) begin
      dyn_vld_ff[sweep_idx_ff] <= 1'b0;
    end
  end

  // Dynamic contents; a refresh restarts the idle time
  always_ff @(posedge sys_clk) begin
    if (learn) begin
      dyn_key_ff[s_idx] <= s_key;
      dyn_port_ff[s_idx] <= frm_port;
      dyn_stamp_ff[s_idx] <= now_sec_ff;
    end
  end

  // ==========================================================
  // Static table management: stage, mark, commit
  logic st_hit_any, st_free_any;
  logic [SAW-1:0] st_hit_idx, st_free_idx;
  always_comb begin
    st_hit_any = 1'b0;
    st_free_any = 1'b0;
    st_hit_idx = '0;
    st_free_idx = '0;
    for (int i = ST_DEPTH - 1; i >= 0; i--) begin
      if ((st_vld_ff[i] || st_add_ff[i]) && st_key_ff[i] == {st_vid_ff, st_mac_ff}) begin
        st_hit_any = 1'b1;
        st_hit_idx = SAW'(i);
      end
      if (!st_vld_ff[i] && !st_add_ff[i]) begin
        st_free_any = 1'b1;
        st_free_idx = SAW'(i);
      end
    end
  end

  logic st_cmd_wr;
  assign st_cmd_wr = wr && (paddr == REG_ST_CMD);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_vld_ff <= '0;
      st_add_ff <= '0;
      st_del_ff <= '0;
      st_full_ff <= 1'b0;
    end else if (st_cmd_wr && pwdata[CMD_COMMIT]) begin
      // Pending deletes leave, pending adds go live
      st_vld_ff <= (st_vld_ff | st_add_ff) & ~st_del_ff;
      st_add_ff <= '0;
      st_del_ff <= '0;
    end else if (st_cmd_wr && pwdata[CMD_ADD]) begin
      st_full_ff <= !st_hit_any && !st_free_any;
      if (st_hit_any) begin
        st_add_ff[st_hit_idx] <= 1'b1;
        st_del_ff[st_hit_idx] <= 1'b0;
      end else if (st_free_any) begin
        st_add_ff[st_free_idx] <= 1'b1;
      end
    end else if (st_cmd_wr && pwdata[CMD_DEL] && st_hit_any) begin
      st_del_ff[st_hit_idx] <= 1'b1;
    end
  end

  // Static contents; staged members apply at commit
  always_ff @(posedge sys_clk) begin
    if (st_cmd_wr && pwdata[CMD_COMMIT]) begin
      for (int i = 0; i < ST_DEPTH; i++) begin
        if (st_add_ff[i]) begin
          st_ports_ff[i] <= st_pend_ff[i];
        end
      end
    end else if (st_cmd_wr && pwdata[CMD_ADD]) begin
      if (st_hit_any) begin
        st_pend_ff[st_hit_idx] <= st_ports_in_ff;
      end else if (st_free_any) begin
        st_key_ff[st_free_idx] <= {st_vid_ff, st_mac_ff};
        st_pend_ff[st_free_idx] <= st_ports_in_ff;
      end
    end
  end

  // ==========================================================
  // Ordered reader: statics first, then every dynamic slot
  logic c_vld, c_static, c_take, rd_start;
  logic [KW-1:0] c_key;
  logic [NPORT-1:0] c_ports;
  assign rd_start = wr && (paddr == REG_RD_CMD) && (scan_st_ff == SC_IDLE)
    && (pwdata[CMD_FIRST] || pwdata[CMD_NEXT]);
  always_comb begin
    c_static = scan_idx_ff < 14'(ST_DEPTH);
    if (c_static) begin
      c_vld = st_vld_ff[scan_idx_ff[SAW-1:0]];
      c_key = st_key_ff[scan_idx_ff[SAW-1:0]];
      c_ports = st_ports_ff[scan_idx_ff[SAW-1:0]];
    end else begin
      c_vld = dyn_vld_ff[DAW'(scan_idx_ff - 14'(ST_DEPTH))];
      c_key = dyn_key_ff[DAW'(scan_idx_ff - 14'(ST_DEPTH))];
      c_ports = NPORT'(1) << dyn_port_ff[DAW'(scan_idx_ff - 14'(ST_DEPTH))];
    end
  end
  // Smallest key at or above the start (above it for get-next)
  assign c_take = c_vld && (strict_ff ? (c_key > base_key_ff) : (c_key >= base_key_ff))
    && (!best_vld_ff || c_key < best_key_ff);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_st_ff <= SC_IDLE;
      scan_idx_ff <= '0;
      strict_ff <= 1'b0;
      base_key_ff <= '0;
      best_vld_ff <= 1'b0;
      best_static_ff <= 1'b0;
      best_key_ff <= '0;
      best_ports_ff <= '0;
      res_key_ff <= '0;
      res_ports_ff <= '0;
      res_static_ff <= 1'b0;
      res_end_ff <= 1'b0;
    end else begin
      unique case (scan_st_ff)
        SC_IDLE: begin
          if (rd_start) begin
            scan_st_ff <= SC_RUN;
            scan_idx_ff <= '0;
            best_vld_ff <= 1'b0;
            strict_ff <= pwdata[CMD_NEXT];
            base_key_ff <= pwdata[CMD_NEXT] ? res_key_ff : {rd_vid_ff, rd_mac_ff};
          end
        end
        SC_RUN: begin
          if (c_take) begin
            best_vld_ff <= 1'b1;
            best_key_ff <= c_key;
            best_ports_ff <= c_ports;
            best_static_ff <= c_static;
          end
          if (scan_idx_ff == SCAN_LAST) begin
            scan_st_ff <= SC_IDLE;
            res_end_ff <= !(best_vld_ff || c_take);
            if (c_take) begin
              res_key_ff <= c_key;
              res_ports_ff <= c_ports;
              res_static_ff <= c_static;
            end else if (best_vld_ff) begin
              res_key_ff <= best_key_ff;
              res_ports_ff <= best_ports_ff;
              res_static_ff <= best_static_ff;
            end
          end else begin
            scan_idx_ff <= scan_idx_ff + 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aging_off_ff <= 1'b0;
      age_time_ff <= AGE_RST;
      lrn_mode_ff <= '0;
      st_vid_ff <= '0;
      st_mac_ff <= '0;
      st_ports_in_ff <= '0;
      rd_vid_ff <= '0;
      rd_mac_ff <= '0;
    end else if (wr) begin
      unique case (paddr)
        REG_CTRL: aging_off_ff <= pwdata[0];
        REG_AGE: begin
          if (pwdata[TW-1:0] >= AGE_MIN && pwdata[TW-1:0] <= AGE_MAX && pwdata[31:TW] == '0) begin
            age_time_ff <= pwdata[TW-1:0];
          end
        end
        REG_LMODE: begin
          for (int p = 0; p < NPORT; p++) begin
            if (!ovr_en[p]) begin
              lrn_mode_ff[2*p +: 2] <= pwdata[2*p +: 2];
            end
          end
        end
        REG_ST_VID: st_vid_ff <= pwdata[VW-1:0];
        REG_ST_MLO: st_mac_ff[31:0] <= pwdata;
        REG_ST_MHI: st_mac_ff[MW-1:32] <= pwdata[15:0];
        REG_ST_PORTS: st_ports_in_ff <= pwdata[NPORT-1:0];
        REG_RD_VID: rd_vid_ff <= pwdata[VW-1:0];
        REG_RD_MLO: rd_mac_ff[31:0] <= pwdata;
        REG_RD_MHI: rd_mac_ff[MW-1:32] <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read mux and unmapped detection
  logic [31:0] rdata;
  logic rerr;
  always_comb begin
    rdata = '0;
    rerr = 1'b0;
    unique case (paddr)
      REG_CTRL: rdata = {31'h0, aging_off_ff};
      REG_AGE: rdata = {8'h00, age_time_ff};
      REG_LMODE: rdata = {16'h0, lrn_mode_ff};
      REG_LOCK: rdata = {24'h0, ovr_en};
      REG_ST_VID: rdata = {20'h0, st_vid_ff};
      REG_ST_MLO: rdata = st_mac_ff[31:0];
      REG_ST_MHI: rdata = {16'h0, st_mac_ff[MW-1:32]};
      REG_ST_PORTS: rdata = {24'h0, st_ports_in_ff};
      REG_ST_CMD: rdata = '0;
      REG_ST_STAT: rdata = {31'h0, st_full_ff};
      REG_RD_VID: rdata = {20'h0, rd_vid_ff};
      REG_RD_MLO: rdata = rd_mac_ff[31:0];
      REG_RD_MHI: rdata = {16'h0, rd_mac_ff[MW-1:32]};
      REG_RD_CMD: rdata = '0;
      REG_RD_STAT: rdata = {29'h0, res_static_ff, res_end_ff, scan_st_ff == SC_RUN};
      REG_RES_VID: rdata = {20'h0, res_key_ff[KW-1:MW]};
      REG_RES_MLO: rdata = res_key_ff[31:0];
      REG_RES_MHI: rdata = {16'h0, res_key_ff[MW-1:32]};
      REG_RES_PORTS: rdata = {24'h0, res_ports_ff};
      default: rerr = 1'b1;
    endcase
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && rerr;
      if (psel && penable && !pready_ff && !pwrite) begin
        prdata_ff <= rdata;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fwd_valid = fwd_valid_ff;
  assign fwd_ports = fwd_ports_ff;
  assign fwd_drop = fwd_drop_ff;
  assign fwd_flood = fwd_flood_ff;

  // ==========================================================
  // Checks
  a_secure_drop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    secure_drop |=> fwd_drop_ff && fwd_ports_ff == '0)
    else $error("secure port forwarded an unknown source");
  a_learn_auto: assert property (@(posedge sys_clk) disable iff (!arst_n)
    frm_valid && eff_mode == LRN_AUTO && !s_st_hit && !dyn_vld_ff[s_idx]
    |=> dyn_vld_ff[$past(s_idx)])
    else $error("auto port did not learn a new source");
  a_learn_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    frm_valid && eff_mode == LRN_OFF && !dyn_vld_ff[s_idx] && !dyn_vld_ff[sweep_idx_ff]
    |=> !dyn_vld_ff[$past(s_idx)])
    else $error("disabled port learned a source");
  a_age_range: assert property (@(posedge sys_clk) disable iff (!arst_n)
    age_time_ff >= AGE_MIN && age_time_ff <= AGE_MAX)
    else $error("age time out of range");
  a_aging_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    aging_off_ff && dyn_vld_ff[sweep_idx_ff] |=> dyn_vld_ff[$past(sweep_idx_ff)])
    else $error("entry aged while aging off");
  a_dst_static: assert property (@(posedge sys_clk) disable iff (!arst_n)
    frm_valid && !secure_drop && d_st_hit
    |=> fwd_ports_ff == ($past(d_st_ports) & ~(NPORT'(1) << $past(frm_port))))
    else $error("static destination not forwarded to its members");
  a_del_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(st_cmd_wr && pwdata[CMD_COMMIT])
    |=> (st_vld_ff & $past(st_vld_ff) & $past(st_del_ff))
    == ($past(st_vld_ff) & $past(st_del_ff)))
    else $error("marked static entry left before commit");
  a_del_commit: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_cmd_wr && pwdata[CMD_COMMIT] |=> (st_vld_ff & $past(st_del_ff)) == '0)
    else $error("marked static entry survived commit");
  a_scan_end: assert property (@(posedge sys_clk) disable iff (!arst_n)
    scan_st_ff == SC_RUN && scan_idx_ff == SCAN_LAST && !best_vld_ff && !c_take
    |=> res_end_ff && scan_st_ff == SC_IDLE)
    else $error("exhausted read did not flag end of table");
endmodule
`default_nettype wire

// ---- sim/mat_frm_src.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Ingress pipeline model: one frame a call, fields scrambled when idle
module mat_frm_src
  import mat_pkg::*;
(
  input wire logic sys_clk,
  output logic frm_valid,
  output logic [PW-1:0] frm_port,
  output logic [VW-1:0] frm_vid,
  output logic [MW-1:0] dst_addr,
  output logic [MW-1:0] src_addr
);
  // Idle at time zero
  initial begin
    frm_valid = 1'b0;
    frm_port = '0;
    frm_vid = '0;
    dst_addr = '0;
    src_addr = '0;
  end
  // Frame stands one cycle; afterwards the fields show inverted values
  task automatic send(input logic [PW-1:0] p, input logic [MW-1:0] d,
                      input logic [MW-1:0] s);
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    frm_port <= p;
    frm_vid <= 12'h005;
    dst_addr <= d;
    src_addr <= s;
    @(posedge sys_clk);
    frm_valid <= 1'b0;
    frm_port <= ~p;
    frm_vid <= 12'hffa;
    dst_addr <= ~d;
    src_addr <= ~s;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
  import mat_pkg::*;
;
  localparam int CPS = 20;
  localparam logic [MW-1:0] KA = 48'h0000_1111_2222;
  localparam logic [MW-1:0] KB = 48'h0000_3333_4444;
  localparam logic [MW-1:0] KC = 48'h0000_5555_6666;
  localparam logic [MW-1:0] KL = 48'h0000_7777_8888;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic frm_valid, fwd_valid, fwd_drop, fwd_flood;
  logic [PW-1:0] frm_port;
  logic [VW-1:0] frm_vid;
  logic [MW-1:0] dst_addr, src_addr;
  logic [NPORT-1:0] ovr_en, fwd_ports;
  logic [2*NPORT-1:0] ovr_mode;
  int n_errors, compares;
  // ==========================================================
  // Design and ingress model
  mat_table #(.CYC_PER_SEC(CPS)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frm_valid(frm_valid), .frm_port(frm_port), .frm_vid(frm_vid),
    .destination_mac_address(dst_addr), .source_mac_address(src_addr),
    .ovr_en(ovr_en), .ovr_mode(ovr_mode), .fwd_valid(fwd_valid),
    .fwd_ports(fwd_ports), .fwd_drop(fwd_drop), .fwd_flood(fwd_flood));
  mat_frm_src u_src (.sys_clk(sys_clk), .frm_valid(frm_valid),
    .frm_port(frm_port), .frm_vid(frm_vid), .dst_addr(dst_addr),
    .src_addr(src_addr));
  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wmac(input logic [7:0] b, input logic [MW-1:0] m);
    apb(1'b1, b, 32'h00000005);
    apb(1'b1, b + 8'h04, m[31:0]);
    apb(1'b1, b + 8'h08, {16'h0000, m[47:32]});
  endtask
  // Start an ordered read and poll until the scanner is idle
  task automatic scan(input logic [31:0] cmd);
    apb(1'b1, REG_RD_CMD, cmd);
    rdat = 32'h00000001;
    while (rdat[0] !== 1'b0) begin
      apb(1'b0, REG_RD_STAT, 32'h0);
    end
  endtask
  // Send a frame on VLAN 5, compare {valid, drop, flood, ports}
  task automatic fr(input logic [PW-1:0] p, input logic [MW-1:0] d,
                    input logic [MW-1:0] s, input logic [10:0] exp);
    u_src.send(p, d, s);
    #1;
    chk({21'h0, fwd_valid, fwd_drop, fwd_flood, fwd_ports}, {21'h0, exp});
  endtask
  task automatic summarize();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog well past the expected run length
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    n_errors = 0;
    compares = 0;
    arst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ovr_en = 8'h00;
    ovr_mode = 16'h0000;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    ovr_en <= 8'h20;
    ovr_mode <= 16'h0400;
    // Age time, refused value, unmapped offset, learning modes
    apb(1'b0, REG_AGE, 32'h0);
    chk(rdat, 32'h0000012c);
    apb(1'b1, REG_AGE, 32'h00000009);
    apb(1'b1, REG_AGE, 32'h00989681);
    apb(1'b0, REG_AGE, 32'h0);
    chk(rdat, 32'h0000012c);
    apb(1'b0, 8'hfc, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, REG_LMODE, 32'h00000980);
    apb(1'b0, REG_LOCK, 32'h0);
    chk(rdat, 32'h00000020);
    $display("test 1 done");
    // Learning and lookup; port 4 is off so its source never learns
    fr(3'h1, KL, KA, 11'h5fd);
    fr(3'h4, KA, KL, 11'h402);
    fr(3'h1, KL, KA, 11'h5fd);
    fr(3'h5, KL, KC, 11'h5df);
    fr(3'h4, KC, KL, 11'h5ef);
    // Static entry staged then committed
    wmac(REG_ST_VID, KB);
    apb(1'b1, REG_ST_PORTS, 32'h00000030);
    apb(1'b1, REG_ST_CMD, 32'h00000001);
    apb(1'b1, REG_ST_CMD, 32'h00000004);
    fr(3'h4, KB, KL, 11'h420);
    fr(3'h3, KL, KA, 11'h600);
    fr(3'h3, KL, KB, 11'h5f7);
    $display("test 2 done");
    // Aging held off so the long scans cannot expire the learned source
    apb(1'b1, REG_CTRL, 32'h00000001);
    // Ordered reads: A dynamic, B static, then end of table
    wmac(REG_RD_VID, 48'h0);
    scan(32'h00000001);
    chk(rdat & 32'h6, 32'h0);
    apb(1'b0, REG_RES_MLO, 32'h0);
    chk(rdat, KA[31:0]);
    apb(1'b0, REG_RES_PORTS, 32'h0);
    chk(rdat, 32'h00000002);
    scan(32'h00000002);
    chk(rdat & 32'h6, 32'h4);
    apb(1'b0, REG_RES_MLO, 32'h0);
    chk(rdat, KB[31:0]);
    apb(1'b0, REG_RES_VID, 32'h0);
    chk(rdat, 32'h00000005);
    scan(32'h00000002);
    chk(rdat & 32'h2, 32'h2);
    fr(3'h4, KA, KL, 11'h402);
    $display("test 3 done");
    // Marked entry forwards until commit
    apb(1'b1, REG_ST_CMD, 32'h00000002);
    fr(3'h4, KB, KL, 11'h420);
    apb(1'b1, REG_ST_CMD, 32'h00000004);
    fr(3'h4, KB, KL, 11'h5ef);
    // Shortest age time removes the idle dynamic entry
    apb(1'b1, REG_CTRL, 32'h00000000);
    apb(1'b1, REG_AGE, 32'h0000000a);
    repeat (12 * CPS + 8400) @(posedge sys_clk);
    fr(3'h4, KA, KL, 11'h5ef);
    $display("test 4 done");
    summarize();
  end
endmodule
`default_nettype wire
